// ===== ssa_attenuator_ctrl.sv
// What this block does
// - Serial words enter the shift register least significant bit first.
// - A low pulse on the clear pin forces all eight shift register bits to zero.
// - A clear followed directly by a select pulse applies the all-zero code.
// - While select is high the serial clock shifts nothing in.
// - While select is low the chained output repeats the input eight clocks later.
// - After power-up the register holds all zeros, maximum attenuation.
// - A one in a code bit takes that step out of the path, a zero puts it in.
// - The word is two reserved bits first, then code bits lowest to highest.
// - All ones is minimum attenuation and all zeros is maximum attenuation.
// - The lowest code bit is a half dB step and higher bits are binary multiples.
// - The rising edge of select moves the shift register into the active code.
// - A falling edge on the clear pin returns the active code to all zeros.
`timescale 1ns/1ps
`include "ssa_cfg.svh"

module ssa_attenuator_ctrl (
   // system clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // serial link pins
   input wire logic sclk_in,
   input wire logic select_n_in,
   input wire logic serial_in_line_in,
   input wire logic clear_n_in,
   // chained serial output
   output logic chained_serial_out,
   // active attenuation state
   output logic [`SSA_CODE_W-1:0] atten_code_out,
   output logic [`SSA_RSV_W-1:0] reserved_out,
   output logic [`SSA_CODE_W-1:0] step_in_path_out,
   output logic [`SSA_CODE_W-1:0] atten_half_db_out,
   // activity
   output logic frame_active_out,
   output logic update_pulse_out,
   output logic [`SSA_COUNT_W-1:0] update_count_out
);

   // ***************************************************************
   // helpers
   // ***************************************************************

   // code field of a serial word
   function automatic logic [`SSA_CODE_W-1:0] code_field(input logic [`SSA_WORD_W-1:0] w);
      code_field = w[`SSA_CODE_HI:`SSA_CODE_LO];
   endfunction : code_field

   // reserved field of a serial word
   function automatic logic [`SSA_RSV_W-1:0] rsv_field(input logic [`SSA_WORD_W-1:0] w);
      rsv_field = w[`SSA_RSV_HI:`SSA_RSV_LO];
   endfunction : rsv_field

   // attenuation in half dB units, all ones gives zero
   function automatic logic [`SSA_CODE_W-1:0] half_db(input logic [`SSA_CODE_W-1:0] c);
      half_db = `SSA_CODE_ALL_ONES - c;
   endfunction : half_db

   // high now after low, a rising edge of a synchronised pin
   function automatic logic rose_edge(input logic now_lvl, input logic prev_lvl);
      rose_edge = (now_lvl == `SSA_LEVEL_HIGH) && (prev_lvl == `SSA_LEVEL_LOW);
   endfunction : rose_edge

   // low now after high, a falling edge of a synchronised pin
   function automatic logic fell_edge(input logic now_lvl, input logic prev_lvl);
      fell_edge = (now_lvl == `SSA_LEVEL_LOW) && (prev_lvl == `SSA_LEVEL_HIGH);
   endfunction : fell_edge

   // ***************************************************************
   // link domain
   // ***************************************************************

   // shifter word and chain bit, link clock domain
   logic link_rst;
   logic [`SSA_WORD_W-1:0] link_word;
   logic link_chain;

   // clear pin or system reset empties the shifter
   assign link_rst = rst_in | ~clear_n_in;

   // serial shifter clocked by the link clock
   ssa_link_shift u_shift (
      .sclk_in(sclk_in),
      .link_rst_in(link_rst),
      .select_n_in(select_n_in),
      .serial_in_line_in(serial_in_line_in),
      .word_out(link_word),
      .chained_serial_out(link_chain)
   );

   // ***************************************************************
   // system domain state
   // ***************************************************************

   // power-up and reset values, pins idle high
   localparam ssa_pkg::ssa_state_type RESET_STATE = '{
      sel_meta: `SSA_LEVEL_HIGH,
      sel_sync: `SSA_LEVEL_HIGH,
      sel_prev: `SSA_LEVEL_HIGH,
      clr_meta: `SSA_LEVEL_HIGH,
      clr_sync: `SSA_LEVEL_HIGH,
      clr_prev: `SSA_LEVEL_HIGH,
      word_meta: `SSA_WORD_RESET,
      word_sync: `SSA_WORD_RESET,
      phase: ssa_pkg::ssa_idle,
      code: `SSA_CODE_RESET,
      rsv: `SSA_RSV_RESET,
      step_in: `SSA_CODE_ALL_ONES,
      atten_half_db: `SSA_CODE_ALL_ONES,
      frame_active: `SSA_LEVEL_LOW,
      update: `SSA_LEVEL_LOW,
      update_count: `SSA_COUNT_RESET
   };

   // registered state and its next value
   ssa_pkg::ssa_state_type s;
   ssa_pkg::ssa_state_type next_s;

   // ***************************************************************
   // next state
   // ***************************************************************

   // synchronisers, frame sequencing and active code
   always_comb begin
      next_s = s;
      // pins pass two flops before any logic reads them
      next_s.sel_meta = select_n_in;
      next_s.sel_sync = s.sel_meta;
      next_s.sel_prev = s.sel_sync;
      next_s.clr_meta = clear_n_in;
      next_s.clr_sync = s.clr_meta;
      next_s.clr_prev = s.clr_sync;
      // word is stable while select is high, so two stages settle it
      next_s.word_meta = link_word;
      next_s.word_sync = s.word_meta;
      // update is a one-cycle pulse
      next_s.update = `SSA_LEVEL_LOW;

      // frame sequencing on the synchronised select
      case (s.phase)
         ssa_pkg::ssa_idle: begin
            if (s.sel_sync == `SSA_LEVEL_LOW) begin
               next_s.phase = ssa_pkg::ssa_frame;
            end
         end
         ssa_pkg::ssa_cleared: begin
            // a select pulse after a clear loads the zeroed word
            if (s.sel_sync == `SSA_LEVEL_LOW) begin
               next_s.phase = ssa_pkg::ssa_frame;
            end
         end
         ssa_pkg::ssa_frame: begin
            // select rising edge moves the word to the active code
            if (rose_edge(s.sel_sync, s.sel_prev)) begin
               next_s.code = code_field(s.word_sync);
               next_s.rsv = rsv_field(s.word_sync);
               next_s.update = `SSA_LEVEL_HIGH;
               next_s.update_count = s.update_count + `SSA_COUNT_ONE;
               next_s.phase = ssa_pkg::ssa_idle;
            end
         end
         default: begin
            next_s.phase = ssa_pkg::ssa_idle;
         end
      endcase

      // clear falling edge returns to maximum attenuation, last word wins
      // a clear and a load in one cycle leave the code at zero
      if (fell_edge(s.clr_sync, s.clr_prev)) begin
         next_s.code = `SSA_CODE_RESET;
         next_s.rsv = `SSA_RSV_RESET;
         next_s.update = `SSA_LEVEL_HIGH;
         if (s.phase != ssa_pkg::ssa_frame) begin
            next_s.phase = ssa_pkg::ssa_cleared;
         end
      end

      // derived views of the active code, and frame activity from the synchronised select
      next_s.step_in = ~next_s.code;
      next_s.atten_half_db = half_db(next_s.code);
      next_s.frame_active = ~s.sel_sync;
   end

   // ***************************************************************
   // registers
   // ***************************************************************

   // power-up state is maximum attenuation
   // reset branch loads constants only
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         s <= RESET_STATE;
      end else begin
         s <= next_s;
      end
   end

   // ***************************************************************
   // outputs
   // ***************************************************************

   // link-domain chain bit, registered in the shifter
   assign chained_serial_out = link_chain;

   // active code and reserved bits
   assign atten_code_out = s.code;
   assign reserved_out = s.rsv;

   // derived views of the active code
   assign step_in_path_out = s.step_in;
   assign atten_half_db_out = s.atten_half_db;

   // activity
   assign frame_active_out = s.frame_active;
   assign update_pulse_out = s.update;
   assign update_count_out = s.update_count;

endmodule : ssa_attenuator_ctrl

// ===== ssa_attenuator_ctrl_props.sv
`timescale 1ns/1ps

module ssa_attenuator_ctrl_props (
   // clocks and reset
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic sclk_in,
   // serial pins
   input wire logic select_n_in,
   input wire logic serial_in_line_in,
   input wire logic clear_n_in,
   // watched outputs
   input wire logic chained_serial_out,
   input wire logic [5:0] atten_code_out,
   input wire logic [5:0] step_in_path_out,
   input wire logic [5:0] atten_half_db_out,
   input wire logic frame_active_out,
   input wire logic update_pulse_out,
   input wire logic [7:0] update_count_out
);
   // nine selected link edges in a row
   sequence s_run;
      !select_n_in [*8] ##1 !select_n_in;
   endsequence
   // pulse after a select rise
   sequence s_load;
      ##[2:5] update_pulse_out;
   endsequence
   // zero code after a clear edge
   sequence s_clr;
      ##[2:4] (update_pulse_out && atten_code_out == 6'h00);
   endsequence

   chk_chain_delay: assert property (@(posedge sclk_in) disable iff (rst_in)
      s_run |=> chained_serial_out == $past(serial_in_line_in, 9)) else $error("chain");
   chk_power_up: assert property (@(posedge clk_in) disable iff (rst_in)
      $fell(rst_in) |-> atten_code_out == 6'h00 && update_count_out == 8'h00) else $error("rst");
   chk_step_polarity: assert property (@(posedge clk_in) disable iff (rst_in)
      step_in_path_out == ~atten_code_out) else $error("step");
   chk_half_db: assert property (@(posedge clk_in) disable iff (rst_in)
      atten_half_db_out == 6'h3F - atten_code_out) else $error("half db");
   chk_clear_code: assert property (@(posedge clk_in) disable iff (rst_in)
      $fell(clear_n_in) |-> s_clr) else $error("clear");
   chk_load_pulse: assert property (@(posedge clk_in) disable iff (rst_in)
      $rose(select_n_in) |-> s_load) else $error("load");
   chk_code_cause: assert property (@(posedge clk_in) disable iff (rst_in)
      $changed(atten_code_out) |-> update_pulse_out) else $error("code");
   chk_count_step: assert property (@(posedge clk_in) disable iff (rst_in)
      $changed(update_count_out) |-> update_count_out == $past(update_count_out) + 8'h01)
      else $error("count");
   chk_frame_track: assert property (@(posedge clk_in) disable iff (rst_in)
      frame_active_out == !$past(select_n_in, 3)) else $error("frame");
endmodule : ssa_attenuator_ctrl_props

bind ssa_attenuator_ctrl ssa_attenuator_ctrl_props u_props (
   .clk_in(clk_in), .rst_in(rst_in), .sclk_in(sclk_in), .select_n_in(select_n_in),
   .serial_in_line_in(serial_in_line_in), .clear_n_in(clear_n_in),
   .chained_serial_out(chained_serial_out), .atten_code_out(atten_code_out),
   .step_in_path_out(step_in_path_out), .atten_half_db_out(atten_half_db_out),
   .update_pulse_out(update_pulse_out), .update_count_out(update_count_out),
   .frame_active_out(frame_active_out));

// ===== ssa_cfg.svh
`ifndef SSA_CFG_SVH
`define SSA_CFG_SVH

// ***************************************************************
// serial word layout
// ***************************************************************
`define SSA_WORD_W 8
`define SSA_CODE_W 6
`define SSA_RSV_W 2
`define SSA_RSV_LO 0
`define SSA_RSV_HI 1
`define SSA_CODE_LO 2
`define SSA_CODE_HI 7
`define SSA_WORD_MSB 7

// ***************************************************************
// reset values and codes
// ***************************************************************
`define SSA_WORD_RESET 8'h00
`define SSA_CODE_RESET 6'h00
`define SSA_RSV_RESET 2'h0
`define SSA_CODE_ALL_ONES 6'h3F
`define SSA_LEVEL_HIGH 1'h1
`define SSA_LEVEL_LOW 1'h0
`define SSA_COUNT_W 8
`define SSA_COUNT_ONE 8'h01
`define SSA_COUNT_RESET 8'h00

`endif

// ===== ssa_host_model.sv
`timescale 1ns/1ps

module ssa_host_model (
   // serial pins driven
   output logic sclk_out,
   output logic select_n_out,
   output logic data_out,
   output logic clear_n_out
);
   // idle: select high, link clock still
   initial begin
      sclk_out = 1'b0;
      select_n_out = 1'b1;
      data_out = 1'b0;
      clear_n_out = 1'b1;
   end

   // n bits lsb first, 64 ns link clock; sel high drives select low to open the frame
   task automatic send(input logic [15:0] w, input int n, input logic sel);
      select_n_out = ~sel;
      #(n < 8 ? 400 : 40);
      for (int i = 0; i < n; i++) begin
         data_out = w[i];
         #32 sclk_out = 1'b1;
         #5 data_out = ~data_out;
         #27 sclk_out = 1'b0;
      end
      #40 select_n_out = 1'b1;
      #600;
   endtask : send

   // clear pulse with setup time before the next frame
   task automatic clear();
      clear_n_out = 1'b0;
      #100 clear_n_out = 1'b1;
      #600;
   endtask : clear
endmodule : ssa_host_model

// ===== ssa_link_shift.sv
`timescale 1ns/1ps
`include "ssa_cfg.svh"

module ssa_link_shift (
   // link clock and clear
   input wire logic sclk_in,
   input wire logic link_rst_in,
   // serial pins
   input wire logic select_n_in,
   input wire logic serial_in_line_in,
   // results
   output logic [`SSA_WORD_W-1:0] word_out,
   output logic chained_serial_out
);

   ssa_pkg::ssa_link_state_type s;
   ssa_pkg::ssa_link_state_type next_s;

   // shift toward bit 0 so the first bit ends lowest
   always_comb begin
      next_s = s;
      if (select_n_in == `SSA_LEVEL_LOW) begin
         next_s.chain = s.word[`SSA_RSV_LO];
         next_s.word = {serial_in_line_in, s.word[`SSA_WORD_MSB:1]};
      end
   end

   // rising edge sampling, clear forces zero
   always_ff @(posedge sclk_in or posedge link_rst_in) begin
      if (link_rst_in) begin
         s.word <= `SSA_WORD_RESET;
         s.chain <= `SSA_LEVEL_LOW;
      end else begin
         s <= next_s;
      end
   end

   assign word_out = s.word;
   assign chained_serial_out = s.chain;

endmodule : ssa_link_shift

// ===== ssa_pkg.sv
`include "ssa_cfg.svh"

package ssa_pkg;

   // ***************************************************************
   // sequencing of the system-clock side
   // ***************************************************************
   typedef enum logic [1:0] {
      ssa_idle,
      ssa_frame,
      ssa_cleared
   } ssa_phase_type;

   // ***************************************************************
   // state of the link-clock shifter
   // ***************************************************************
   typedef struct packed {
      logic [`SSA_WORD_W-1:0] word;
      logic chain;
   } ssa_link_state_type;

   // ***************************************************************
   // state of the system-clock side
   // ***************************************************************
   typedef struct packed {
      logic sel_meta;
      logic sel_sync;
      logic sel_prev;
      logic clr_meta;
      logic clr_sync;
      logic clr_prev;
      logic [`SSA_WORD_W-1:0] word_meta;
      logic [`SSA_WORD_W-1:0] word_sync;
      ssa_phase_type phase;
      logic [`SSA_CODE_W-1:0] code;
      logic [`SSA_RSV_W-1:0] rsv;
      logic [`SSA_CODE_W-1:0] step_in;
      logic [`SSA_CODE_W-1:0] atten_half_db;
      logic frame_active;
      logic update;
      logic [`SSA_COUNT_W-1:0] update_count;
   } ssa_state_type;

endpackage : ssa_pkg

// ===== tb.sv
`timescale 1ns/1ps

module tb;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic sclk, sel_n, sdata, clr_n, chain, pulse;
   logic [5:0] code;
   logic [1:0] rsv;
   logic [7:0] count;
   logic [8:0] exp_q[$];
   logic [8:0] n;
   logic [15:0] w;
   logic [15:0] tab[4] = '{16'h00FC, 16'h0003, 16'h0000, 16'h00FE};
   int err_total = 0;
   int tests_run = 0;
   int cyc = 0;
   int loads = 0;

   // 10 MHz system clock
   always #50 clk_in = ~clk_in;

   ssa_host_model u_ssa_host_model (.sclk_out(sclk), .select_n_out(sel_n), .data_out(sdata),
      .clear_n_out(clr_n));
   ssa_attenuator_ctrl u_ssa_attenuator_ctrl (.clk_in(clk_in), .rst_in(rst_in), .sclk_in(sclk),
      .select_n_in(sel_n), .serial_in_line_in(sdata), .clear_n_in(clr_n),
      .chained_serial_out(chain), .atten_code_out(code), .reserved_out(rsv),
      .step_in_path_out(), .atten_half_db_out(), .frame_active_out(),
      .update_pulse_out(pulse), .update_count_out(count));

   // compare and count
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: %h vs %h", $time, got, exp);
      end
   endtask : check

   // report and stop
   task automatic end_sim();
      $display("checks %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_sim

   // frame after an edge, noting the word that lands
   task automatic load(input logic [15:0] v, input int k, input logic [8:0] e);
      @(posedge clk_in);
      #2;
      exp_q.push_back(e);
      u_ssa_host_model.send(v, k, 1'b1);
      loads++;
   endtask : load

   // each update against the oldest note
   always @(negedge clk_in) begin
      if (pulse === 1'b1) begin
         n = (exp_q.size() > 0) ? exp_q.pop_front() : {1'b1, ~code, ~rsv};
         check({code, n[8] ? rsv : n[1:0]}, n[7:0]);
      end
   end

   // hang guard
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 2000) begin
         err_total++;
         end_sim();
      end
   end

   // main sequence
   initial begin
      void'($urandom(4));
      repeat (3) @(posedge clk_in);
      #2 rst_in = 1'b0;
      repeat (3) @(posedge clk_in);
      #2;
      check({code, rsv}, 8'h00);
      check({7'h00, chain}, 8'h00);
      $display("test reset done");
      for (int i = 0; i < 10; i++) begin
         w = (i < 4) ? tab[i] : 16'($urandom);
         load(w, 8, {1'b1, w[7:0]});
      end
      $display("test load done");
      w = 16'($urandom) | 16'h8000;
      load(w, 16, {1'b1, w[15:8]});
      check({7'h00, chain}, {7'h00, w[7]});
      $display("test chain done");
      @(posedge clk_in);
      #2;
      u_ssa_host_model.send(~w, 8, 1'b0);
      load(16'h0000, 0, {1'b1, w[15:8]});
      $display("test inhibit done");
      @(posedge clk_in);
      #2;
      exp_q.push_back(9'h000);
      u_ssa_host_model.clear();
      load(16'h0000, 0, 9'h100);
      check(count, 8'(loads));
      $display("test clear done");
      @(posedge clk_in);
      #2 rst_in = 1'b1;
      @(posedge clk_in);
      #2 rst_in = 1'b0;
      check({code, rsv}, 8'h00);
      check(count, 8'h00);
      check({7'h00, chain}, 8'h00);
      $display("test rerun done");
      end_sim();
   end
endmodule : tb
